// >>> rtl/gating_pkg.sv
package gating_pkg;

  // Core clock
  localparam int CLK_FREQ_HZ = 250_000_000;
  // Internal time base: one tick per millisecond
  localparam real TICK_S = 0.001;
  localparam int TICK_CYCLES_DEF = int'(TICK_S * CLK_FREQ_HZ);

  // Width of every millisecond counter (holds 150000)
  localparam int TIME_W = 18;

  // Timing figures in seconds, and their counts in ticks
  localparam real PRESS_MIN_S = 0.15;
  localparam real PRESS_MAX_S = 4.0;
  localparam real OVR_MAX_S = 120.0;
  localparam real INTERLOCK_S = 150.0;
  localparam real LAMP_HALF_S = 0.5;
  localparam logic [TIME_W-1:0] PRESS_MIN_TICKS = TIME_W'(int'(PRESS_MIN_S / TICK_S));
  localparam logic [TIME_W-1:0] PRESS_MAX_TICKS = TIME_W'(int'(PRESS_MAX_S / TICK_S));
  localparam logic [TIME_W-1:0] OVR_MAX_TICKS = TIME_W'(int'(OVR_MAX_S / TICK_S));
  localparam logic [TIME_W-1:0] INTERLOCK_TICKS = TIME_W'(int'(INTERLOCK_S / TICK_S));
  localparam logic [TIME_W-1:0] LAMP_HALF_TICKS = TIME_W'(int'(LAMP_HALF_S / TICK_S));

  // Values after reset
  localparam logic [TIME_W-1:0] TIME_RESET = 18'h00000;
  localparam logic [31:0] PRESC_RESET = 32'h00000000;

  // Sequencing states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_WAIT,
    ST_ARMED,
    ST_OVERRIDE,
    ST_LAPSED,
    ST_INTERLOCK
  } gate_state_t;

endpackage : gating_pkg

// >>> rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Raw pins and filtered levels
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);

  // Three stages per bit; the level moves only when stages two and three agree
  for (genvar g = 0; g < W; g++) begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        lvl_r <= 1'b0;
      end else begin
        s1_r <= i_pin[g];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          lvl_r <= s3_r;
        end
      end
    end
    assign o_level[g] = lvl_r;
  end

endmodule : pin_sync
`default_nettype wire

// >>> rtl/gating_restart_override_logic.sv
`timescale 1ns/10ps
`default_nettype none
module gating_restart_override_logic #(
  parameter int TICK_CYCLES = gating_pkg::TICK_CYCLES_DEF
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Operator and machine controller pins
  input wire logic i_restart_button_input,
  input wire logic i_gating_switch,
  // Optical state from the receiver core
  input wire logic i_field_interrupted,
  input wire logic i_sync_beam_a_blocked,
  input wire logic i_sync_beam_b_blocked,
  input wire logic i_outputs_tripped,
  // Error handling from the diagnostic core
  input wire logic i_error_active,
  input wire logic i_error_reset,
  // Outputs
  output logic o_safety_switch_outputs,
  output logic o_status_lamp_output,
  output logic o_restart_required,
  output logic o_override_required,
  output logic o_gating_continue,
  output logic o_interlock
);

  logic [1:0] pins;
  logic btn, gate, btn_d_r, btn_rise, btn_fall;
  logic [31:0] presc_r;
  logic tick_r;
  logic [gating_pkg::TIME_W-1:0] press_r, ovr_r, lamp_cnt_r;
  logic press_valid_r, press_in_range;
  logic lamp_r, err_hold_r, err_block;
  logic restart_need, override_need, gating_valid;
  logic safety_r, restart_req_r, override_req_r, lock_r;
  logic cont_r, cont_nxt;
  gating_pkg::gate_state_t state_r, state_nxt;

  // Button and gating switch come from outside the clock domain
  pin_sync #(
    .W(2)
  ) u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_pin({i_gating_switch, i_restart_button_input}),
    .o_level(pins)
  );
  assign btn = pins[0];
  assign gate = pins[1];

  // Decision terms
  assign restart_need = i_field_interrupted && gate &&
                        !(i_sync_beam_a_blocked && i_sync_beam_b_blocked);
  assign override_need = i_field_interrupted && gate &&
                         i_sync_beam_a_blocked && i_sync_beam_b_blocked;
  assign gating_valid = gate && i_field_interrupted;
  assign err_block = err_hold_r || i_error_active;
  assign btn_rise = btn && !btn_d_r;
  assign btn_fall = !btn && btn_d_r;
  assign press_in_range = (press_r >= gating_pkg::PRESS_MIN_TICKS) &&
                          (press_r <= gating_pkg::PRESS_MAX_TICKS);

  // Millisecond time base; a prescaler keeps the long counters narrow
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      presc_r <= gating_pkg::PRESC_RESET;
      tick_r <= 1'b0;
    end else if (presc_r == 32'(TICK_CYCLES - 1)) begin
      presc_r <= gating_pkg::PRESC_RESET;
      tick_r <= 1'b1;
    end else begin
      presc_r <= presc_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  // Press duration measurement, saturating just past the maximum
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      btn_d_r <= 1'b0;
      press_r <= gating_pkg::TIME_RESET;
      press_valid_r <= 1'b0;
    end else begin
      btn_d_r <= btn;
      press_valid_r <= btn_fall && press_in_range;
      if (btn_rise) begin
        press_r <= gating_pkg::TIME_RESET;
      end else if (btn && tick_r && press_r <= gating_pkg::PRESS_MAX_TICKS) begin
        press_r <= press_r + 18'h00001;
      end
    end
  end

  // Error latch; a new error in the reset cycle wins over the clear
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      err_hold_r <= 1'b0;
    end else if (i_error_active) begin
      err_hold_r <= 1'b1;
    end else if (i_error_reset) begin
      err_hold_r <= 1'b0;
    end
  end

  // Override duration, counted only in OVERRIDE and LAPSED, cleared in every other state
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ovr_r <= gating_pkg::TIME_RESET;
    end else if (state_r != gating_pkg::ST_OVERRIDE && state_r != gating_pkg::ST_LAPSED) begin
      ovr_r <= gating_pkg::TIME_RESET;
    end else if (tick_r && ovr_r < gating_pkg::INTERLOCK_TICKS) begin
      ovr_r <= ovr_r + 18'h00001;
    end
  end

  // Sequencing; a press is only acted on once the error is cleared
  always_comb begin
    state_nxt = state_r;
    cont_nxt = 1'b0;
    case (state_r)
      gating_pkg::ST_RUN: begin
        if (i_outputs_tripped) begin
          state_nxt = gating_pkg::ST_WAIT;
        end
      end
      gating_pkg::ST_WAIT: begin
        if (press_valid_r && !err_block) begin
          if (restart_need) begin
            state_nxt = gating_pkg::ST_RUN;
            cont_nxt = gating_valid;
          end else if (override_need) begin
            state_nxt = gating_pkg::ST_ARMED;
          end
        end
      end
      gating_pkg::ST_ARMED: begin
        if (btn_rise && !err_block) begin
          if (gating_valid && !override_need) begin
            state_nxt = gating_pkg::ST_RUN;
            cont_nxt = 1'b1;
          end else begin
            state_nxt = gating_pkg::ST_OVERRIDE;
          end
        end
      end
      gating_pkg::ST_OVERRIDE: begin
        if (!btn) begin
          state_nxt = gating_pkg::ST_WAIT;
        end else if (ovr_r >= gating_pkg::OVR_MAX_TICKS) begin
          state_nxt = gating_pkg::ST_LAPSED;
        end
      end
      gating_pkg::ST_LAPSED: begin
        if (!btn) begin
          state_nxt = gating_pkg::ST_WAIT;
        end else if (ovr_r >= gating_pkg::INTERLOCK_TICKS) begin
          state_nxt = gating_pkg::ST_INTERLOCK;
        end
      end
      gating_pkg::ST_INTERLOCK: begin
        // Step-by-step override: press and hold again to go on
        if (btn_rise && !err_block) begin
          state_nxt = gating_pkg::ST_OVERRIDE;
        end
      end
      default: begin
        state_nxt = gating_pkg::ST_WAIT;
      end
    endcase
  end

  // State and registered outputs; outputs start off after reset for safety
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= gating_pkg::ST_WAIT;
      safety_r <= 1'b0;
      cont_r <= 1'b0;
      lock_r <= 1'b0;
      restart_req_r <= 1'b0;
      override_req_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      safety_r <= (state_nxt == gating_pkg::ST_RUN) ||
                  (state_nxt == gating_pkg::ST_OVERRIDE);
      cont_r <= cont_nxt;
      lock_r <= (state_nxt == gating_pkg::ST_INTERLOCK);
      restart_req_r <= restart_need;
      override_req_r <= override_need;
    end
  end

  // Lamp blinks while outputs are off; steady low once they are on
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lamp_cnt_r <= gating_pkg::TIME_RESET;
      lamp_r <= 1'b0;
    end else if (safety_r) begin
      lamp_cnt_r <= gating_pkg::TIME_RESET;
      lamp_r <= 1'b0;
    end else if (tick_r) begin
      if (lamp_cnt_r >= gating_pkg::LAMP_HALF_TICKS - 18'h00001) begin
        lamp_cnt_r <= gating_pkg::TIME_RESET;
        lamp_r <= !lamp_r;
      end else begin
        lamp_cnt_r <= lamp_cnt_r + 18'h00001;
      end
    end
  end

  assign o_safety_switch_outputs = safety_r;
  assign o_status_lamp_output = lamp_r;
  assign o_restart_required = restart_req_r;
  assign o_override_required = override_req_r;
  assign o_gating_continue = cont_r;
  assign o_interlock = lock_r;

  // Checks
  sequence s_valid_press;
    state_r == gating_pkg::ST_WAIT && press_valid_r && !err_block;
  endsequence
  sequence s_outputs_on;
    safety_r && (state_r == gating_pkg::ST_RUN);
  endsequence
  property p_restart_on;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    s_valid_press and restart_need |=> s_outputs_on;
  endproperty
  a_restart_on: assert property (p_restart_on) else $error("restart did not enable outputs");

  property p_error_blocks;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (state_r == gating_pkg::ST_WAIT) && err_block |=> !safety_r;
  endproperty
  a_error_blocks: assert property (p_error_blocks) else $error("restart taken during error");
  // Only a press released while waiting may arm anything; in RUN the outputs rightly stay on
  property p_short_ignored;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (state_r == gating_pkg::ST_WAIT) && btn_fall && (press_r < gating_pkg::PRESS_MIN_TICKS) |=>
    !press_valid_r ##1 !safety_r;
  endproperty
  a_short_ignored: assert property (p_short_ignored) else $error("short press accepted");
  property p_long_ignored;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    btn_fall && (press_r > gating_pkg::PRESS_MAX_TICKS) |=> !press_valid_r;
  endproperty
  a_long_ignored: assert property (p_long_ignored) else $error("long press accepted");
  property p_override_armed;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    s_valid_press and override_need |=> (state_r == gating_pkg::ST_ARMED) && !safety_r;
  endproperty
  a_override_armed: assert property (p_override_armed) else $error("override not armed");
  property p_need_exclusive;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    o_restart_required |-> !o_override_required;
  endproperty
  a_need_exclusive: assert property (p_need_exclusive) else $error("both needs flagged");

  property p_release_drops;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (state_r == gating_pkg::ST_OVERRIDE) && !btn |=> !safety_r;
  endproperty
  a_release_drops: assert property (p_release_drops) else $error("override held after release");

  property p_override_limit;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    safety_r && (state_r == gating_pkg::ST_OVERRIDE) |-> ovr_r <= gating_pkg::OVR_MAX_TICKS;
  endproperty
  a_override_limit: assert property (p_override_limit) else $error("override ran past limit");

  property p_continue;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    (state_r == gating_pkg::ST_ARMED) && btn_rise && !err_block && gating_valid &&
    !override_need |=> s_outputs_on ##0 o_gating_continue;
  endproperty
  a_continue: assert property (p_continue) else $error("gating not continued");

  property p_lamp_blinks;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !safety_r && tick_r && (lamp_cnt_r >= gating_pkg::LAMP_HALF_TICKS - 18'h00001)
    |=> safety_r || (lamp_r != $past(lamp_r));
  endproperty
  a_lamp_blinks: assert property (p_lamp_blinks) else $error("lamp did not toggle");

endmodule : gating_restart_override_logic
`default_nettype wire

// >>> testbench/operator_model.sv
`timescale 1ns/10ps
`default_nettype none
module operator_model (
  // Clock
  input wire logic i_ref_clk,
  // Pins towards the block
  output logic o_button,
  output logic o_gating
);
  // Both pins idle low: button released, gating switch off
  initial begin
    o_button = 1'b0;
    o_gating = 1'b0;
  end

  // Press, hold n cycles, release; the length decides short, valid or long
  task automatic press(input int n);
    @(negedge i_ref_clk);
    o_button = 1'b1;
    repeat (n) @(negedge i_ref_clk);
    o_button = 1'b0;
  endtask : press

  // Open-ended hold, used for the override second press
  task automatic hold(input logic lvl);
    @(negedge i_ref_clk);
    o_button = lvl;
  endtask : hold

  // Machine controller gating switch level
  task automatic set_gating(input logic lvl);
    @(negedge i_ref_clk);
    o_gating = lvl;
  endtask : set_gating
endmodule : operator_model
`default_nettype wire

// >>> testbench/gating_restart_override_logic_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module gating_restart_override_logic_tb_top;
  logic clk, reset_n, btn, gate, field, beam_a, beam_b, tripped, err_act, err_rst;
  logic outs, lamp, rst_req, ovr_req, gcont, ilock;
  logic [1:0] exp_q[$];
  int n_mismatch = 0;
  int tests_run = 0;
  logic [31:0] lfsr = 32'h000179e3;

  operator_model i_op (.i_ref_clk(clk), .o_button(btn), .o_gating(gate));

  // One tick per clock keeps every press short in simulation
  gating_restart_override_logic #(.TICK_CYCLES(1)) i_dut (
    .i_ref_clk(clk), .i_reset_n(reset_n), .i_restart_button_input(btn),
    .i_gating_switch(gate), .i_field_interrupted(field),
    .i_sync_beam_a_blocked(beam_a), .i_sync_beam_b_blocked(beam_b),
    .i_outputs_tripped(tripped), .i_error_active(err_act), .i_error_reset(err_rst),
    .o_safety_switch_outputs(outs), .o_status_lamp_output(lamp),
    .o_restart_required(rst_req), .o_override_required(ovr_req),
    .o_gating_continue(gcont), .o_interlock(ilock));

  // 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic end_sim();
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("[ERR] %0t expected output events never seen", $time);
    end
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk_lvl(input logic act, input logic exp, input string what);
    tests_run++;
    if (act !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %b want %b", $time, what, act, exp);
    end
  endtask : chk_lvl

  task automatic chk_evt(input logic [1:0] act, input logic [1:0] exp);
    tests_run++;
    if (act !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t output event got %b want %b", $time, act, exp);
    end
  endtask : chk_evt

  task automatic wait_c(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_c

  // Lamp must change level within one full period plus margin
  task automatic lamp_blinks();
    logic l0;
    int k;
    l0 = lamp;
    k = 0;
    while (lamp === l0 && k < 1100) begin
      @(negedge clk);
      k++;
    end
    chk_lvl(lamp !== l0, 1'b1, "lamp toggle");
  endtask : lamp_blinks

  // Each change of the outputs, or a continue pulse, consumes the oldest note
  initial begin
    logic prev;
    prev = 1'b0;
    forever begin
      @(negedge clk);
      if (reset_n && (outs !== prev || gcont === 1'b1)) begin
        chk_evt({gcont, outs}, exp_q.size() ? exp_q.pop_front() : 2'bxx);
      end
      prev = outs;
    end
  end

  // Watchdog: a hang counts as a mismatch
  initial begin
    #300000;
    n_mismatch++;
    $display("[ERR] %0t run did not finish", $time);
    end_sim();
  end

  initial begin
    reset_n = 1'b0;
    {field, beam_a, beam_b, tripped, err_act, err_rst} = 6'h00;
    wait_c(8);
    reset_n = 1'b1;
    // Need terms under random optical, gating, trip and error patterns; trips do nothing in WAIT
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      {err_rst, err_act, tripped, field, beam_b, beam_a} = lfsr[5:0];
      i_op.set_gating(lfsr[6]);
      wait_c(10);
      chk_lvl(rst_req, lfsr[2] && lfsr[6] && !(lfsr[0] && lfsr[1]), "restart need");
      chk_lvl(ovr_req, lfsr[2] && lfsr[6] && lfsr[0] && lfsr[1], "override need");
    end
    // Field on, no beams, no trip, and an error reset to drop any latched random error
    {field, beam_a, beam_b, tripped, err_act, err_rst} = 6'h21;
    wait_c(1);
    err_rst = 1'b0;
    i_op.set_gating(1'b0);
    wait_c(10);
    chk_lvl(rst_req, 1'b0, "restart need without gating");
    beam_a = 1'b1;
    i_op.set_gating(1'b1);
    lamp_blinks();
    $display("need terms done");
    // Short and long presses are ignored; the gap lets the pin filter see two presses
    lfsr = lfsr_next(lfsr);
    i_op.press(20 + int'(lfsr[6:0]));
    wait_c(20);
    chk_lvl(outs, 1'b0, "outputs after short press");
    i_op.press(4100 + int'(lfsr[14:7]));
    wait_c(20);
    chk_lvl(outs, 1'b0, "outputs after bad presses");
    $display("press limits done");
    // Error blocks restart until an error reset is made
    err_act = 1'b1;
    i_op.press(300);
    wait_c(20);
    err_act = 1'b0;
    i_op.press(300);
    wait_c(20);
    chk_lvl(outs, 1'b0, "outputs while error latched");
    err_rst = 1'b1;
    wait_c(1);
    err_rst = 1'b0;
    lfsr = lfsr_next(lfsr);
    exp_q.push_back(2'h3);
    i_op.press(200 + int'(lfsr[10:0]));
    wait_c(20);
    chk_lvl(lamp, 1'b0, "lamp with outputs on");
    $display("error and restart done");
    // Trip switches outputs off, lamp resumes
    exp_q.push_back(2'h0);
    tripped = 1'b1;
    wait_c(1);
    tripped = 1'b0;
    lamp_blinks();
    $display("trip done");
    // Override: outputs follow the held button
    beam_b = 1'b1;
    wait_c(10);
    chk_lvl(ovr_req, 1'b1, "override need both beams");
    i_op.press(300);
    wait_c(20);
    chk_lvl(outs, 1'b0, "outputs while armed");
    exp_q.push_back(2'h1);
    i_op.hold(1'b1);
    wait_c(50);
    exp_q.push_back(2'h0);
    i_op.hold(1'b0);
    wait_c(20);
    $display("override done");
    // Valid gating at the second press continues gating
    i_op.press(300);
    wait_c(20);
    beam_b = 1'b0;
    exp_q.push_back(2'h3);
    i_op.hold(1'b1);
    wait_c(30);
    i_op.hold(1'b0);
    wait_c(20);
    chk_lvl(outs, 1'b1, "outputs kept after release");
    exp_q.push_back(2'h0);
    tripped = 1'b1;
    wait_c(1);
    tripped = 1'b0;
    wait_c(20);
    chk_lvl(ilock, 1'b0, "no interlock");
    $display("gating continue done");
    // Mid-run reset clears the registered outputs; the need returns once the pins settle
    reset_n = 1'b0;
    wait_c(2);
    chk_lvl(rst_req, 1'b0, "restart need in reset");
    chk_lvl(lamp, 1'b0, "lamp in reset");
    reset_n = 1'b1;
    wait_c(10);
    chk_lvl(rst_req, 1'b1, "restart need after reset");
    $display("reset done");
    end_sim();
  end
endmodule : gating_restart_override_logic_tb_top
`default_nettype wire
